// File: hdl/status_pin_pkg.sv
/*
 Shared constants and types for the status pin mode and reset control block:
 register offsets, field positions, reset values, mode codes and timing counts.
 Assumes a 200 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none

package status_pin_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int         ADDR_W          = 8;
  localparam logic [7:0] CONFIG_OFS      = 8'h00;
  localparam logic [7:0] READ_CFG_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS      = 8'h08;
  localparam logic [7:0] CLEAR_OFS       = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_OFS  = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS    = 8'h14;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          MODE_W          = 2;
  localparam int          SR_READY        = 7;
  localparam int          SR_ERASE_SUSP   = 6;
  localparam int          SR_ERASE_ERR    = 5;
  localparam int          SR_PROG_ERR     = 4;
  localparam int          SR_PROG_SUSP    = 2;
  localparam int          SR_RECOVERING   = 8;
  localparam int          CLEAR_BIT       = 0;
  localparam int          SYNC_READ_BIT   = 0;
  localparam int          IRQ_ERASE_DONE  = 0;
  localparam int          IRQ_PROG_DONE   = 1;
  localparam int          IRQ_CFG_ERR     = 2;
  localparam int          IRQ_RECOVERED   = 3;
  localparam int          IRQ_W           = 4;
  localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;
  localparam logic        SYNC_READ_RESET = 1'b0;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int PULSE_NS        = 250;
  localparam int RECOVERY_NS     = 210;
  localparam int CNT_W           = 8;
  // Typical pulse width, exact at this clock
  localparam int PULSE_CYCLES    = (PULSE_NS * 1000) / CLK_PERIOD_PS;
  // Least time, rounded up
  localparam int RECOVERY_CYCLES = (RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    STS_LEVEL         = 2'h0,
    STS_PULSE_ERASE   = 2'h1,
    STS_PULSE_PROGRAM = 2'h2,
    STS_PULSE_BOTH    = 2'h3
  } sts_mode_t;

  typedef enum logic [1:0] {
    PS_IDLE,
    PS_LOW,
    PS_GAP
  } pulse_state_t;

  // Activity reported by the write state machine
  typedef struct packed {
    logic busy;
    logic eraseSuspended;
    logic programSuspended;
    logic eraseDone;
    logic programDone;
    logic eraseFail;
    logic programFail;
  } wsm_in_t;

endpackage

`default_nettype wire

// File: hdl/status_pin_mode_and_reset.sv
/*
 Status output pin mode control and reset handling of a flash device, with an
 AXI4-Lite register slave, error status bits and a maskable interrupt.
 Assumes write state machine inputs are synchronous to core_clk and that
 done and fail inputs are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none

module status_pin_mode_and_reset
  import status_pin_pkg::*;
#(
  parameter int PULSE_LEN    = PULSE_CYCLES,
  parameter int RECOVERY_LEN = RECOVERY_CYCLES
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire wsm_in_t           wsmIn,
  output logic                   stsOut,
  output logic                   stsOeN,
  output logic                   dataOeN,
  output logic                   wsmAbort,
  output logic                   syncReadEn,
  output logic                   irq,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic              awFull_q,  awFull_d;
  logic [ADDR_W-1:0] awAddr_q,  awAddr_d;
  logic              wFull_q,   wFull_d;
  logic [31:0]       wData_q,   wData_d;
  logic [3:0]        wStrb_q,   wStrb_d;
  logic              awRdy_q,   awRdy_d;
  logic              wRdy_q,    wRdy_d;
  logic              bValid_q,  bValid_d;
  logic [1:0]        bResp_q,   bResp_d;
  logic              arRdy_q,   arRdy_d;
  logic              rValid_q,  rValid_d;
  logic [31:0]       rData_q,   rData_d;
  logic [1:0]        rResp_q,   rResp_d;
  logic              doWrite;

  sts_mode_t         mode_q,    mode_d;
  logic              syncRd_q,  syncRd_d;
  logic              eraseErr_q, eraseErr_d;
  logic              progErr_q, progErr_d;
  logic [CNT_W-1:0]  recov_q,   recov_d;
  pulse_state_t      pState_q,  pState_d;
  logic [CNT_W-1:0]  pCnt_q,    pCnt_d;
  logic [1:0]        pend_q,    pend_d;
  logic              sts_q,     sts_d;
  logic              stsOeN_q,  stsOeN_d;
  logic              dataOeN_q, dataOeN_d;
  logic              abort_q,   abort_d;
  logic [IRQ_W-1:0]  irqSts_q,  irqSts_d;
  logic [IRQ_W-1:0]  irqMask_q, irqMask_d;
  logic              irq_q,     irq_d;

  logic              wrLane0;
  logic              cfgWr;
  logic              cfgBad;
  logic              clrWr;
  logic              eraseHit;
  logic              progHit;
  logic [IRQ_W-1:0]  irqEvents;
  logic [31:0]       statusWord;

  // Decode of the register map
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return (a == CONFIG_OFS) || (a == READ_CFG_OFS) || (a == STATUS_OFS) ||
           (a == CLEAR_OFS) || (a == IRQ_STATUS_OFS) || (a == IRQ_MASK_OFS);
  endfunction

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  // Address and data captured in either order; write fires once both held
  always_comb begin
    awFull_d = awFull_q;
    awAddr_d = awAddr_q;
    wFull_d  = wFull_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    bValid_d = bValid_q;
    bResp_d  = bResp_q;
    rValid_d = rValid_q;
    rData_d  = rData_q;
    rResp_d  = rResp_q;
    doWrite  = awFull_q && wFull_q && !bValid_q;
    if (s_axi_awvalid && awRdy_q) begin
      awFull_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wRdy_q) begin
      wFull_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (doWrite) begin
      awFull_d = 1'b0;
      wFull_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (s_axi_arvalid && arRdy_q) begin
      rValid_d = 1'b1;
      rResp_d  = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        CONFIG_OFS:     rData_d = {30'h0, mode_q};
        READ_CFG_OFS:   rData_d = {31'h0, syncRd_q};
        STATUS_OFS:     rData_d = statusWord;
        IRQ_STATUS_OFS: rData_d = {28'h0, irqSts_q};
        IRQ_MASK_OFS:   rData_d = {28'h0, irqMask_q};
        default:        rData_d = 32'h0;
      endcase
    end else if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
    // One write and one read in flight at most
    awRdy_d = !awFull_d && !bValid_d;
    wRdy_d  = !wFull_d && !bValid_d;
    arRdy_d = !rValid_d;
    if (!reset_n) begin
      awFull_d = 1'b0;
      wFull_d  = 1'b0;
      bValid_d = 1'b0;
      rValid_d = 1'b0;
      awRdy_d  = 1'b0;
      wRdy_d   = 1'b0;
      arRdy_d  = 1'b0;
      awAddr_d = '0;
      wData_d  = 32'h0;
      wStrb_d  = 4'h0;
      bResp_d  = RESP_OKAY;
      rData_d  = 32'h0;
      rResp_d  = RESP_OKAY;
    end
  end

  always_ff @(posedge core_clk) begin
    awFull_q <= awFull_d;
    awAddr_q <= awAddr_d;
    wFull_q  <= wFull_d;
    wData_q  <= wData_d;
    wStrb_q  <= wStrb_d;
    awRdy_q  <= awRdy_d;
    wRdy_q   <= wRdy_d;
    bValid_q <= bValid_d;
    bResp_q  <= bResp_d;
    arRdy_q  <= arRdy_d;
    rValid_q <= rValid_d;
    rData_q  <= rData_d;
    rResp_q  <= rResp_d;
  end

  // ****************************************************************
  // Register writes and status word
  // ****************************************************************
  // All writable fields live in byte 0, so lane 0 gates every write effect
  assign wrLane0  = doWrite && wStrb_q[0];
  assign cfgWr    = wrLane0 && (awAddr_q == CONFIG_OFS);
  assign cfgBad   = cfgWr && (wData_q[31:MODE_W] != '0);
  assign clrWr    = wrLane0 && (awAddr_q == CLEAR_OFS) && wData_q[CLEAR_BIT];
  // Qualifying completions for the present pulse mode
  assign eraseHit = wsmIn.eraseDone &&
                    (mode_q == STS_PULSE_ERASE || mode_q == STS_PULSE_BOTH);
  assign progHit  = wsmIn.programDone &&
                    (mode_q == STS_PULSE_PROGRAM || mode_q == STS_PULSE_BOTH);

  // Both error bits plus ready is how software spots a sequence error
  always_comb begin
    statusWord                = 32'h0;
    statusWord[SR_READY]      = !wsmIn.busy;
    statusWord[SR_ERASE_SUSP] = wsmIn.eraseSuspended;
    statusWord[SR_ERASE_ERR]  = eraseErr_q;
    statusWord[SR_PROG_ERR]   = progErr_q;
    statusWord[SR_PROG_SUSP]  = wsmIn.programSuspended;
    statusWord[SR_RECOVERING] = (recov_q != '0);
  end

  // ****************************************************************
  // Mode, error bits, pin and reset control
  // ****************************************************************
  always_comb begin
    mode_d     = mode_q;
    syncRd_d   = syncRd_q;
    pState_d   = pState_q;
    pCnt_d     = pCnt_q;
    pend_d     = pend_q;
    irqMask_d  = irqMask_q;
    recov_d    = (recov_q != '0) ? recov_q - 1'b1 : recov_q;
    // A valid code changes the mode; bad codes or writes while busy or suspended leave it
    if (cfgWr && !cfgBad && !wsmIn.busy &&
        !wsmIn.eraseSuspended && !wsmIn.programSuspended) begin
      mode_d   = sts_mode_t'(wData_q[MODE_W-1:0]);
      pend_d   = 2'h0;
      pState_d = PS_IDLE;
    end
    if (wrLane0 && awAddr_q == READ_CFG_OFS) begin
      syncRd_d = wData_q[SYNC_READ_BIT];
    end
    if (wrLane0 && awAddr_q == IRQ_MASK_OFS) begin
      irqMask_d = wData_q[IRQ_W-1:0];
    end
    // Hardware only sets errors; clear command drops them, set wins
    eraseErr_d = (eraseErr_q && !clrWr) || wsmIn.eraseFail || cfgBad;
    progErr_d  = (progErr_q && !clrWr) || wsmIn.programFail || cfgBad;
    // Completions queue, up to three, while a pulse runs
    if (!(cfgWr && !cfgBad)) begin
      if (eraseHit && progHit) begin
        pend_d = (pend_q >= 2'h2) ? 2'h3 : pend_q + 2'h2;
      end else if (eraseHit || progHit) begin
        pend_d = (pend_q == 2'h3) ? 2'h3 : pend_q + 2'h1;
      end
    end
    unique case (pState_q)
      PS_IDLE: begin
        if (pend_q != 2'h0 && mode_d == mode_q) begin
          pState_d = PS_LOW;
          pCnt_d   = CNT_W'(PULSE_LEN - 1);
          pend_d   = pend_d - 2'h1;
        end
      end
      PS_LOW: begin
        if (pCnt_q == '0) begin
          pState_d = PS_GAP;
        end else begin
          pCnt_d = pCnt_q - 1'b1;
        end
      end
      PS_GAP: begin
        // Two high cycles between back-to-back pulses keep them distinct
        pState_d = PS_IDLE;
      end
    endcase
    // Pin: busy level in level mode, low pulses otherwise
    if (mode_d == STS_LEVEL) begin
      sts_d = !wsmIn.busy;
    end else begin
      sts_d = (pState_d != PS_LOW);
    end
    stsOeN_d  = 1'b0;
    dataOeN_d = (recov_d != '0);
    abort_d   = 1'b0;
    irqEvents                 = '0;
    irqEvents[IRQ_ERASE_DONE] = wsmIn.eraseDone;
    irqEvents[IRQ_PROG_DONE]  = wsmIn.programDone;
    irqEvents[IRQ_CFG_ERR]    = cfgBad;
    irqEvents[IRQ_RECOVERED]  = (recov_q == CNT_W'(1));
    // Write-one-to-clear, a new event in the same cycle wins
    irqSts_d = irqSts_q | irqEvents;
    if (wrLane0 && awAddr_q == IRQ_STATUS_OFS) begin
      irqSts_d = (irqSts_q & ~wData_q[IRQ_W-1:0]) | irqEvents;
    end
    if (!reset_n) begin
      mode_d     = STS_LEVEL;
      syncRd_d   = SYNC_READ_RESET;
      eraseErr_d = 1'b0;
      progErr_d  = 1'b0;
      recov_d    = CNT_W'(RECOVERY_LEN);
      pState_d   = PS_IDLE;
      pCnt_d     = '0;
      pend_d     = 2'h0;
      sts_d      = 1'b1;
      stsOeN_d   = 1'b1;
      dataOeN_d  = 1'b1;
      abort_d    = 1'b1;
      irqSts_d   = '0;
      irqMask_d  = IRQ_MASK_RESET;
    end
    irq_d = |(irqSts_d & irqMask_d);
  end

  always_ff @(posedge core_clk) begin
    mode_q     <= mode_d;
    syncRd_q   <= syncRd_d;
    eraseErr_q <= eraseErr_d;
    progErr_q  <= progErr_d;
    recov_q    <= recov_d;
    pState_q   <= pState_d;
    pCnt_q     <= pCnt_d;
    pend_q     <= pend_d;
    sts_q      <= sts_d;
    stsOeN_q   <= stsOeN_d;
    dataOeN_q  <= dataOeN_d;
    abort_q    <= abort_d;
    irqSts_q   <= irqSts_d;
    irqMask_q  <= irqMask_d;
    irq_q      <= irq_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign stsOut        = sts_q;
  assign stsOeN        = stsOeN_q;
  assign dataOeN       = dataOeN_q;
  assign wsmAbort      = abort_q;
  assign syncReadEn    = syncRd_q;
  assign irq           = irq_q;
  assign s_axi_awready = awRdy_q;
  assign s_axi_wready  = wRdy_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arRdy_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

endmodule

`default_nettype wire

// File: testbench/status_pin_chk.sv
/*
 Port checker for status_pin_mode_and_reset.
 Assumes one clock and a synchronous active-low reset; bound by name.
*/
`timescale 1ns/1ps
`default_nettype none
module status_pin_chk
  import status_pin_pkg::*;
#(
  parameter int PULSE_LEN    = PULSE_CYCLES,
  parameter int RECOVERY_LEN = RECOVERY_CYCLES
) (
  input wire logic              core_clk,
  input wire logic              reset_n,
  input wire wsm_in_t           wsmIn,
  input wire logic              stsOut,
  input wire logic              stsOeN,
  input wire logic              dataOeN,
  input wire logic              wsmAbort,
  input wire logic              syncReadEn,
  input wire logic              irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid
);
  // ****************
  // Helper state
  // ****************
  logic [ADDR_W-1:0] awQ;
  logic [31:0]       wdQ;
  logic [7:0]        lowCnt;
  logic [7:0]        recCnt;
  logic              bvQ;
  sts_mode_t         modeQ;

  // Mode mirror lags one edge; configs only arrive while idle, so that is harmless
  always_ff @(posedge core_clk) begin
    if (s_axi_awvalid && s_axi_awready) awQ <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wdQ <= s_axi_wdata;
    bvQ <= s_axi_bvalid;
    lowCnt <= stsOut ? 8'h00 : lowCnt + 8'h01;
    recCnt <= !reset_n ? 8'h00 : recCnt + {7'h00, recCnt != 8'hFF};
    if (!reset_n) modeQ <= STS_LEVEL;
    else if (s_axi_bvalid && !bvQ && awQ == CONFIG_OFS && wdQ[31:2] == 30'h0) modeQ <= sts_mode_t'(wdQ[1:0]);
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_reset_state: assert property ($rose(reset_n) |-> stsOut && stsOeN && dataOeN && wsmAbort && !irq)
    else $error("outputs not in reset state");
  chk_release_drive: assert property ($rose(reset_n) |=> !stsOeN && !wsmAbort && !syncReadEn)
    else $error("pin not driven after reset");
  chk_recovery_gate: assert property ($fell(dataOeN) |-> recCnt >= RECOVERY_LEN && recCnt <= RECOVERY_LEN + 2)
    else $error("recovery length wrong");
  chk_level_busy: assert property (modeQ == STS_LEVEL |=> stsOut == !$past(wsmIn.busy))
    else $error("level mode does not follow busy");
  chk_pulse_width: assert property (modeQ != STS_LEVEL && $rose(stsOut) |-> lowCnt == PULSE_LEN)
    else $error("pulse width wrong");
  chk_pulse_start: assert property (stsOut[*4] ##0 ((modeQ[0] && wsmIn.eraseDone) || (modeQ[1] && wsmIn.programDone))
    |-> ##[2:3] !stsOut)
    else $error("no pulse after completion");
  chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_bus_resp: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (awQ > IRQ_MASK_OFS ? RESP_SLVERR : RESP_OKAY))
    else $error("write response code wrong");

  cover property (modeQ == STS_PULSE_BOTH && $fell(stsOut));
  cover property ($rose(irq));
  cover property ($fell(dataOeN));
endmodule

bind status_pin_mode_and_reset status_pin_chk #(.PULSE_LEN(PULSE_LEN), .RECOVERY_LEN(RECOVERY_LEN)) chk_inst (.*);
`default_nettype wire

// File: testbench/wsm_model.sv
/*
 Stand-in for the write state machine that feeds wsmIn.
 Assumes startOp is a one-cycle request: 1 erase, 2 program.
*/
`timescale 1ns/1ps
`default_nettype none
module wsm_model
  import status_pin_pkg::*;
#(
  parameter int BUSY_LEN = 4
) (
  input  wire logic       core_clk,
  input  wire logic       wsmAbort,
  input  wire logic [1:0] startOp,
  output var  wsm_in_t    wsmIn
);
  // ****************
  // Operation timer
  // ****************
  logic [7:0] cntQ  = 8'h00;
  logic       progQ = 1'b0;

  initial wsmIn = '0;

  // Busy for BUSY_LEN cycles then one done cycle; suspend and fail stay low
  always @(posedge core_clk) begin
    wsmIn.eraseDone   <= 1'b0;
    wsmIn.programDone <= 1'b0;
    if (wsmAbort) begin
      cntQ       <= 8'h00; // Aborted work never completes
      wsmIn.busy <= 1'b0;
    end else if (startOp != 2'h0) begin
      cntQ       <= 8'(BUSY_LEN);
      progQ      <= startOp[1];
      wsmIn.busy <= 1'b1;
    end else if (cntQ != 8'h00) begin
      cntQ              <= cntQ - 8'h01;
      wsmIn.busy        <= cntQ != 8'h01;
      wsmIn.eraseDone   <= cntQ == 8'h01 && !progQ;
      wsmIn.programDone <= cntQ == 8'h01 && progQ;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_status_pin_mode_and_reset.sv
/*
 Self-checking bench for the status pin block with a state machine stand-in.
 Assumes shortened pulse and recovery lengths (8 and 6 cycles) and a 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_status_pin_mode_and_reset
  import status_pin_pkg::*;
;
  // ****************
  // Stimulus and checks
  // ****************
  localparam int PULSE_LEN    = 8;
  localparam int RECOVERY_LEN = 6;
  localparam int BUSY_LEN     = 4;

  logic              core_clk = 1'b0;
  logic              reset_n  = 1'b0;
  wsm_in_t           wsmIn;
  logic              stsOut, stsOeN, dataOeN, wsmAbort, syncReadEn, irq;
  logic [1:0]        startOp = 2'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic              s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  int                fails = 0, checksDone = 0, cycles = 0;

  status_pin_mode_and_reset #(.PULSE_LEN(PULSE_LEN), .RECOVERY_LEN(RECOVERY_LEN)) status_pin_mode_and_reset_inst (.*);
  wsm_model #(.BUSY_LEN(BUSY_LEN)) wsm_model_inst (.core_clk(core_clk), .wsmAbort(wsmAbort), .startOp(startOp),
    .wsmIn(wsmIn));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // Hang guard: the run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    if (fails == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ready lines stay high, so each answer is taken at the edge it is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    check("bresp", 32'(s_axi_bresp), 32'(a > IRQ_MASK_OFS ? RESP_SLVERR : RESP_OKAY));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    check("rdata", s_axi_rdata, exp);
    check("rresp", 32'(s_axi_rresp), 32'(a > IRQ_MASK_OFS ? RESP_SLVERR : RESP_OKAY));
  endtask

  // One operation, then count low samples of the pin over a fixed window
  task automatic run_op(input logic [1:0] op, input int expLow);
    int n;
    n = 0;
    startOp <= op;
    @(posedge core_clk);
    startOp <= 2'h0;
    repeat (40) begin
      @(posedge core_clk);
      n += (stsOut === 1'b0) ? 1 : 0;
    end
    check("lowCycles", 32'(n), 32'(expLow));
  endtask

  task automatic t_reset();
    reset_n <= 1'b0; // Held from power-up on the first call, asserted mid-erase by t_abort
    repeat (3) @(posedge core_clk);
    check("stsOeN", 32'(stsOeN), 32'h1);
    check("wsmAbort", 32'(wsmAbort), 32'h1);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("stsOut", 32'(stsOut), 32'h1);
    repeat (RECOVERY_LEN + 2) @(posedge core_clk);
    check("dataOeN", 32'(dataOeN), 32'h0);
    check("syncReadEnRst", 32'(syncReadEn), 32'h0);
    rd(READ_CFG_OFS, 32'h0);
    rd(STATUS_OFS, 32'h80);
  endtask

  task automatic t_modes();
    run_op(2'h1, BUSY_LEN);
    for (int c = 1; c < 4; c++) begin
      wr(CONFIG_OFS, 32'(c)); // issued only while idle
      run_op(2'h1, c[0] ? PULSE_LEN : 0);
      run_op(2'h2, c[1] ? PULSE_LEN : 0);
    end
    wr(CONFIG_OFS, 32'h0);
    run_op(2'h2, BUSY_LEN);
  endtask

  task automatic t_invalid();
    wr(CONFIG_OFS, 32'h2);
    wr(CONFIG_OFS, 32'h5);
    rd(STATUS_OFS, 32'hB0);
    run_op(2'h2, PULSE_LEN);
    rd(STATUS_OFS, 32'hB0);
    wr(CLEAR_OFS, 32'h1);
    rd(STATUS_OFS, 32'h80);
    check("irqMasked", 32'(irq), 32'h0);
    wr(IRQ_MASK_OFS, 32'h4);
    @(posedge core_clk);
    check("irqRaised", 32'(irq), 32'h1);
    wr(IRQ_STATUS_OFS, 32'h4);
    @(posedge core_clk);
    check("irqCleared", 32'(irq), 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0);
  endtask

  // Reset lands in mid-erase; the pin must come back in level mode
  task automatic t_abort();
    wr(CONFIG_OFS, 32'h3);
    // Leave synchronous reads on so the reset visibly restores page mode
    wr(READ_CFG_OFS, 32'h1);
    check("syncReadEn", 32'(syncReadEn), 32'h1);
    startOp <= 2'h1;
    @(posedge core_clk);
    startOp <= 2'h0;
    repeat (2) @(posedge core_clk);
    t_reset();
    run_op(2'h1, BUSY_LEN);
  endtask

  initial begin
    t_reset();
    t_modes();
    t_invalid();
    t_abort();
    summarize();
  end
endmodule
`default_nettype wire
